// ===== rtl/power_reduction_mode_control.sv
// Power reduction mode controller: mode sequencing, clock gating and wake logic.
//
// Overview of operation
// [R1] Mode comes from the low two bits of the power control register.
// [R2] Mode 00 is normal running; it is the value after reset.
// [R3] Mode 01 halts execution while peripherals keep their clocks.
// [R4] Idle ends on any enabled interrupt or any enabled reset.
// [R5] Mode 10 stops the main oscillator.
// [R6] Power down ends on reset or external, brownout, keyboard, timer, watchdog, comparator.
// [R7] Reset wakes only if enabled; interrupt needs its enable and global enable.
// [R8] RC oscillator off in power down unless it clocks system and timer runs.
// [R9] On wake, restart oscillator at once, resume only once stable.
// [R10] Stability wait is 1024 clocks for crystal, 256 for RC or external.
// [R11] Comparators run in power down unless their power-off bit set and disabled.
// [R12] Real-time timer runs in power down unless its power-off bit is one.
// [R13] Mode 11 is power down plus brownout and comparators switched off.
// [R14] Total power down gives no brownout reset and no brownout interrupt.
// [R15] Comparator and brownout interrupts do not wake total power down.
// [R16] Total power down wakes only from watchdog, external, keyboard, timer; the code also wakes it on an enabled reset.
// [R17] Watchdog with its clock-select set runs in power down and can wake.
// [R18] Interrupt wake services the interrupt, then resumes after the mode write.
`timescale 1ns/1ps
module power_reduction_mode_control #(
    parameter int unsigned XTAL_CYC = pwr_mode_pkg::STABLE_XTAL_CYC,
    parameter int unsigned RC_CYC   = pwr_mode_pkg::STABLE_RC_CYC
) (
    // Clock and reset
    input  wire logic                               CLK,
    input  wire logic                               ARST_N,
    // Power control register access from the core
    input  wire logic                               MODE_WE,
    input  wire logic [pwr_mode_pkg::MODE_W-1:0]    MODE_WDATA,
    // Configuration from other control registers
    input  wire logic                               GLOBAL_IRQ_ENABLE,
    input  wire logic [pwr_mode_pkg::NUM_IRQ-1:0]   IRQ_ENABLE,
    input  wire logic                               XTAL_SELECTED,
    input  wire logic                               RC_IS_SYSCLK,
    input  wire logic                               RTC_ENABLE,
    input  wire logic                               RTC_POWER_OFF,
    input  wire logic                               CMP_POWER_OFF,
    input  wire logic                               CMP_ENABLE,
    input  wire logic                               WATCHDOG_CLOCK_SELECT,
    // Wake sources from peripherals and pins
    input  wire logic [pwr_mode_pkg::NUM_IRQ-1:0]   IRQ_REQ,
    input  wire logic                               RESET_REQ,
    input  wire logic                               RESET_ENABLE,
    input  wire logic                               WDT_RESET_REQ,
    // Status and gating outputs
    output logic      [pwr_mode_pkg::MODE_W-1:0]    POWER_MODE,
    output logic                                    CPU_RUN,
    output logic                                    PERIPH_CLK_EN,
    output logic                                    OSC_EN,
    output logic                                    RC_OSC_EN,
    output logic                                    BROWNOUT_EN,
    output logic                                    CMP_EN,
    output logic                                    RTC_RUN,
    output logic                                    WDT_RUN,
    output logic                                    WAKE_RESET,
    output logic                                    WAKE_IRQ
);

    // Wake inputs come from pins and other domains, so they are synchronised.
    localparam int unsigned SW = pwr_mode_pkg::NUM_IRQ + 2;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {WDT_RESET_REQ, RESET_REQ, IRQ_REQ};
            sync2_r <= sync1_r;
        end
    end

    logic [pwr_mode_pkg::NUM_IRQ-1:0] irq_s;
    logic                             rst_s;
    logic                             wdt_rst_s;
    assign irq_s     = sync2_r[pwr_mode_pkg::NUM_IRQ-1:0];
    assign rst_s     = sync2_r[pwr_mode_pkg::NUM_IRQ];
    assign wdt_rst_s = sync2_r[pwr_mode_pkg::NUM_IRQ+1];

    pwr_mode_pkg::pwr_state_t state_r;
    pwr_mode_pkg::pwr_state_t state_nxt;
    logic [pwr_mode_pkg::MODE_W-1:0] mode_r;
    logic [pwr_mode_pkg::CNT_W-1:0]  cnt_r;
    logic                            rst_wake_r;

    // Per-source wake qualification for each mode.
    logic [pwr_mode_pkg::NUM_IRQ-1:0] irq_ok;
    logic [pwr_mode_pkg::NUM_IRQ-1:0] pd_ok;
    logic [pwr_mode_pkg::NUM_IRQ-1:0] tpd_ok;
    genvar g;
    generate
        for (g = 0; g < pwr_mode_pkg::NUM_IRQ; g++) begin : g_wake
            assign irq_ok[g] = irq_s[g] & IRQ_ENABLE[g] & GLOBAL_IRQ_ENABLE; // R7
            assign pd_ok[g]  = irq_ok[g]; // R6
            assign tpd_ok[g] = irq_ok[g] & pwr_mode_pkg::TOTAL_WAKE_MASK[g]; // R15 R16
        end
    endgenerate

    logic wdt_alive;
    logic rst_ok;
    logic wake_pd;
    logic wake_tpd;
    logic wake_idle;
    // In power down the watchdog keeps ticking only on its own clock; otherwise it can't wake.
    assign wdt_alive = WATCHDOG_CLOCK_SELECT; // R17
    assign rst_ok    = (rst_s & RESET_ENABLE) | (wdt_rst_s & wdt_alive); // R7 R17
    assign wake_idle = |irq_ok | rst_ok; // R4
    assign wake_pd   = |(pd_ok & {1'b1, wdt_alive, 4'hf}) | rst_ok; // R6 R17
    assign wake_tpd  = |(tpd_ok & {1'b1, wdt_alive, 4'hf}) | rst_ok; // R16 R17

    logic [pwr_mode_pkg::CNT_W-1:0] wait_len;
    assign wait_len = XTAL_SELECTED ? pwr_mode_pkg::CNT_W'(XTAL_CYC - 1)
                                    : pwr_mode_pkg::CNT_W'(RC_CYC - 1); // R10

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pwr_mode_pkg::ST_RUN: begin
                if (MODE_WE) begin
                    case (MODE_WDATA)
                        pwr_mode_pkg::MODE_IDLE:  state_nxt = pwr_mode_pkg::ST_IDLE; // R3
                        pwr_mode_pkg::MODE_PDOWN: state_nxt = pwr_mode_pkg::ST_PDOWN; // R5
                        pwr_mode_pkg::MODE_TOTAL: state_nxt = pwr_mode_pkg::ST_TOTAL; // R13
                        default:                  state_nxt = pwr_mode_pkg::ST_RUN; // R2
                    endcase
                end
            end
            pwr_mode_pkg::ST_IDLE: begin
                if (wake_idle) state_nxt = pwr_mode_pkg::ST_RUN; // R4
            end
            pwr_mode_pkg::ST_PDOWN: begin
                if (wake_pd) state_nxt = pwr_mode_pkg::ST_STABLE; // R9
            end
            pwr_mode_pkg::ST_TOTAL: begin
                if (wake_tpd) state_nxt = pwr_mode_pkg::ST_STABLE; // R9
            end
            pwr_mode_pkg::ST_STABLE: begin
                if (cnt_r == '0) state_nxt = pwr_mode_pkg::ST_RUN; // R9
            end
            default: state_nxt = pwr_mode_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) state_r <= pwr_mode_pkg::ST_RUN;
        else         state_r <= state_nxt;
    end

    // Stability counter loads on wake and counts down to zero.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_r <= '0;
        end else if (state_r != pwr_mode_pkg::ST_STABLE &&
                     state_nxt == pwr_mode_pkg::ST_STABLE) begin
            cnt_r <= wait_len; // R10
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // The mode field clears on wake so that execution carries on in normal mode
    // after the interrupt handler returns to the instruction after the write.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode_r <= pwr_mode_pkg::MODE_RESET_VAL; // R2
        end else if (state_nxt == pwr_mode_pkg::ST_RUN && state_r != pwr_mode_pkg::ST_RUN) begin
            mode_r <= pwr_mode_pkg::MODE_NORMAL; // R18
        end else if (MODE_WE && state_r == pwr_mode_pkg::ST_RUN) begin
            mode_r <= MODE_WDATA; // R1
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_wake_r <= 1'b0;
        end else begin
            // The wake cause is latched on leaving sleep, since the wait would hide it.
            if (state_r != pwr_mode_pkg::ST_RUN && state_r != pwr_mode_pkg::ST_STABLE
                && state_nxt != state_r)
                rst_wake_r <= rst_ok;
        end
    end

    // Gating outputs, registered from next-state so they track state_r; POWER_MODE is registered from mode_r.
    logic sleep_nxt;
    logic tot_nxt;
    assign sleep_nxt = (state_nxt == pwr_mode_pkg::ST_PDOWN) ||
                       (state_nxt == pwr_mode_pkg::ST_TOTAL);
    assign tot_nxt   = (state_nxt == pwr_mode_pkg::ST_TOTAL);

    // A return to run from idle or from the stability wait, and whether a reset caused it.
    logic back_to_run;
    logic woke_by_rst;
    assign back_to_run = (state_nxt == pwr_mode_pkg::ST_RUN) &&
                         (state_r == pwr_mode_pkg::ST_STABLE ||
                          state_r == pwr_mode_pkg::ST_IDLE);
    assign woke_by_rst = (state_r == pwr_mode_pkg::ST_IDLE) ? rst_ok : rst_wake_r;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            POWER_MODE    <= pwr_mode_pkg::MODE_RESET_VAL;
            CPU_RUN       <= 1'b1;
            PERIPH_CLK_EN <= 1'b1;
            OSC_EN        <= 1'b1;
            RC_OSC_EN     <= 1'b1;
            BROWNOUT_EN   <= 1'b1;
            CMP_EN        <= 1'b1;
            RTC_RUN       <= 1'b1;
            WDT_RUN       <= 1'b1;
            WAKE_RESET    <= 1'b0;
            WAKE_IRQ      <= 1'b0;
        end else begin
            POWER_MODE    <= mode_r;
            CPU_RUN       <= (state_nxt == pwr_mode_pkg::ST_RUN); // R3 R9
            PERIPH_CLK_EN <= !sleep_nxt; // R3
            OSC_EN        <= !sleep_nxt; // R5 R9
            RC_OSC_EN     <= !sleep_nxt || (RC_IS_SYSCLK && RTC_ENABLE); // R8
            BROWNOUT_EN   <= !tot_nxt; // R13 R14
            CMP_EN        <= !tot_nxt && !(sleep_nxt && CMP_POWER_OFF && !CMP_ENABLE); // R11 R13
            RTC_RUN       <= !(sleep_nxt && RTC_POWER_OFF); // R12
            WDT_RUN       <= !sleep_nxt || wdt_alive; // R17
            WAKE_RESET    <= back_to_run && woke_by_rst; // R4 R6
            WAKE_IRQ      <= back_to_run && !woke_by_rst; // R18
        end
    end

    // Assertion helper: cycles spent in the stability wait, and the clock choice that set it.
    logic [pwr_mode_pkg::CNT_W-1:0] wait_seen_r;
    logic                           wait_xtal_r;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wait_seen_r <= '0;
            wait_xtal_r <= 1'b0;
        end else if (state_r != pwr_mode_pkg::ST_STABLE) begin
            wait_seen_r <= '0;
            wait_xtal_r <= XTAL_SELECTED;
        end else begin
            wait_seen_r <= wait_seen_r + 1'b1;
        end
    end

    // Brownout and comparator requests must never end total power down.
    no_bo_wake_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R15
        (state_r == pwr_mode_pkg::ST_TOTAL && !rst_ok &&
         !irq_ok[pwr_mode_pkg::IRQ_EXT] && !irq_ok[pwr_mode_pkg::IRQ_KEYBOARD] &&
         !irq_ok[pwr_mode_pkg::IRQ_RTC] && !irq_ok[pwr_mode_pkg::IRQ_WATCHDOG]) |=>
        state_r == pwr_mode_pkg::ST_TOTAL)
        else $error("total power down left without a permitted source");
    brownout_off_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R14
        state_r == pwr_mode_pkg::ST_TOTAL |-> !BROWNOUT_EN)
        else $error("brownout enabled in total power down");
    osc_stop_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R5
        (state_r == pwr_mode_pkg::ST_PDOWN) |-> !OSC_EN && !CPU_RUN)
        else $error("oscillator or cpu running in power down");
    osc_restart_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R9
        (state_r == pwr_mode_pkg::ST_STABLE) |-> OSC_EN && !CPU_RUN)
        else $error("oscillator off or cpu early during stability wait");
    stable_len_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R10
        (state_r == pwr_mode_pkg::ST_STABLE && state_nxt == pwr_mode_pkg::ST_RUN) |->
        wait_seen_r == (wait_xtal_r ? pwr_mode_pkg::CNT_W'(XTAL_CYC - 1)
                                    : pwr_mode_pkg::CNT_W'(RC_CYC - 1)))
        else $error("stability wait has the wrong length");
    idle_wake_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R4
        (state_r == pwr_mode_pkg::ST_IDLE && wake_idle) |=> state_r == pwr_mode_pkg::ST_RUN)
        else $error("idle not left on enabled wake");
    idle_periph_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R3
        state_r == pwr_mode_pkg::ST_IDLE |-> PERIPH_CLK_EN && !CPU_RUN)
        else $error("idle gating wrong");
    gated_irq_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R7
        (state_r == pwr_mode_pkg::ST_IDLE && !GLOBAL_IRQ_ENABLE && !rst_ok) |=>
        state_r == pwr_mode_pkg::ST_IDLE)
        else $error("woke with global interrupt enable clear");
    rtc_off_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R12
        (state_r == pwr_mode_pkg::ST_PDOWN && $past(RTC_POWER_OFF) && RTC_POWER_OFF) |-> !RTC_RUN)
        else $error("timer running with power off bit set");
    rc_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R8
        ((state_r == pwr_mode_pkg::ST_PDOWN || state_r == pwr_mode_pkg::ST_TOTAL) &&
         $past(RC_IS_SYSCLK && RTC_ENABLE)) |-> RC_OSC_EN)
        else $error("rc oscillator stopped while clocking the timer");
    mode_write_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R1
        (MODE_WE && state_r == pwr_mode_pkg::ST_RUN) |->
        ##2 POWER_MODE == $past(MODE_WDATA, 2))
        else $error("mode field does not show the written value");
    normal_run_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R2
        state_r == pwr_mode_pkg::ST_RUN |->
        CPU_RUN && OSC_EN && PERIPH_CLK_EN && BROWNOUT_EN && CMP_EN)
        else $error("power reduction active in normal mode");
    pdown_wake_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R6
        (state_r == pwr_mode_pkg::ST_PDOWN && (rst_ok ||
         irq_ok[pwr_mode_pkg::IRQ_EXT] || irq_ok[pwr_mode_pkg::IRQ_BROWNOUT] ||
         irq_ok[pwr_mode_pkg::IRQ_KEYBOARD] || irq_ok[pwr_mode_pkg::IRQ_RTC] ||
         irq_ok[pwr_mode_pkg::IRQ_COMPARATOR])) |=> state_r == pwr_mode_pkg::ST_STABLE)
        else $error("power down not left on a permitted wake source");
    cmp_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R11
        (state_r == pwr_mode_pkg::ST_PDOWN && !$past(CMP_POWER_OFF)) |-> CMP_EN)
        else $error("comparators stopped without their power-off bit");
    rtc_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R12
        (state_r == pwr_mode_pkg::ST_PDOWN && !$past(RTC_POWER_OFF)) |-> RTC_RUN)
        else $error("timer stopped without its power-off bit");
    total_off_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R13
        state_r == pwr_mode_pkg::ST_TOTAL |-> !CMP_EN && !OSC_EN && !CPU_RUN)
        else $error("comparators or oscillator running in total power down");
    total_wake_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R16
        (state_r == pwr_mode_pkg::ST_TOTAL && (irq_ok[pwr_mode_pkg::IRQ_EXT] ||
         irq_ok[pwr_mode_pkg::IRQ_KEYBOARD] || irq_ok[pwr_mode_pkg::IRQ_RTC])) |=>
        state_r == pwr_mode_pkg::ST_STABLE)
        else $error("total power down not left on a permitted source");
    wdt_wake_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R17
        ((state_r == pwr_mode_pkg::ST_PDOWN || state_r == pwr_mode_pkg::ST_TOTAL) &&
         WATCHDOG_CLOCK_SELECT && (wdt_rst_s || irq_ok[pwr_mode_pkg::IRQ_WATCHDOG])) |=>
        state_r == pwr_mode_pkg::ST_STABLE)
        else $error("watchdog on its own clock did not wake the device");
    wake_pulse_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R18
        WAKE_IRQ |-> CPU_RUN ##1 !WAKE_IRQ)
        else $error("interrupt wake pulse wrong");
    mode_clear_a: assert property (@(posedge CLK) disable iff (!ARST_N) // R18
        (WAKE_IRQ || WAKE_RESET) |=> POWER_MODE == pwr_mode_pkg::MODE_NORMAL)
        else $error("mode field not back to normal after wake");

endmodule // power_reduction_mode_control

// ===== rtl/pwr_mode_pkg.sv
// Constants and types shared by the power reduction mode controller.
package pwr_mode_pkg;
    localparam int unsigned MODE_W          = 2;
    localparam logic [1:0]  MODE_NORMAL     = 2'h0;
    localparam logic [1:0]  MODE_IDLE       = 2'h1;
    localparam logic [1:0]  MODE_PDOWN      = 2'h2;
    localparam logic [1:0]  MODE_TOTAL      = 2'h3;
    localparam int unsigned MODE_LOW_POS    = 0;
    localparam int unsigned MODE_HIGH_POS   = 1;
    localparam logic [1:0]  MODE_RESET_VAL  = 2'h0;
    localparam int unsigned STABLE_XTAL_CYC = 1024;
    localparam int unsigned STABLE_RC_CYC   = 256;
    localparam int unsigned CNT_W           = 11;
    localparam int unsigned NUM_IRQ         = 6;
    localparam int unsigned IRQ_EXT         = 0;
    localparam int unsigned IRQ_BROWNOUT    = 1;
    localparam int unsigned IRQ_KEYBOARD    = 2;
    localparam int unsigned IRQ_RTC         = 3;
    localparam int unsigned IRQ_WATCHDOG    = 4;
    localparam int unsigned IRQ_COMPARATOR  = 5;
    localparam logic [5:0]  TOTAL_WAKE_MASK = 6'h1d;

    typedef enum logic [4:0] {
        ST_RUN    = 5'h01,
        ST_IDLE   = 5'h02,
        ST_PDOWN  = 5'h04,
        ST_TOTAL  = 5'h08,
        ST_STABLE = 5'h10
    } pwr_state_t;
endpackage

// ===== verif/power_reduction_mode_control_test.sv
// Self-checking bench for the power reduction mode controller.
`timescale 1ns/1ps
module power_reduction_mode_control_test;
    localparam int unsigned XTAL_N = 16;
    localparam int unsigned RC_N   = 8;
    logic       CLK = 1'b0;
    logic       ARST_N, MODE_WE, GLOBAL_IRQ_ENABLE, XTAL_SELECTED, RC_IS_SYSCLK, RTC_ENABLE;
    logic       RTC_POWER_OFF, CMP_POWER_OFF, CMP_ENABLE, WATCHDOG_CLOCK_SELECT, drop;
    logic       RESET_REQ, RESET_ENABLE, WDT_RESET_REQ, saw_irq, saw_rst;
    logic       CPU_RUN, PERIPH_CLK_EN, OSC_EN, RC_OSC_EN, BROWNOUT_EN, CMP_EN, RTC_RUN;
    logic       WDT_RUN, WAKE_RESET, WAKE_IRQ;
    logic [1:0] MODE_WDATA, POWER_MODE;
    logic [5:0] IRQ_ENABLE, IRQ_REQ, raise;
    int         fails = 0, checks = 0, cycles = 0, n;
    int         total_src[4] = '{0, 2, 3, 4};

    power_reduction_mode_control #(.XTAL_CYC(XTAL_N), .RC_CYC(RC_N)) u_dut (
        .CLK(CLK), .ARST_N(ARST_N), .MODE_WE(MODE_WE), .MODE_WDATA(MODE_WDATA),
        .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .IRQ_ENABLE(IRQ_ENABLE),
        .XTAL_SELECTED(XTAL_SELECTED), .RC_IS_SYSCLK(RC_IS_SYSCLK), .RTC_ENABLE(RTC_ENABLE),
        .RTC_POWER_OFF(RTC_POWER_OFF), .CMP_POWER_OFF(CMP_POWER_OFF), .CMP_ENABLE(CMP_ENABLE),
        .WATCHDOG_CLOCK_SELECT(WATCHDOG_CLOCK_SELECT), .IRQ_REQ(IRQ_REQ),
        .RESET_REQ(RESET_REQ), .RESET_ENABLE(RESET_ENABLE), .WDT_RESET_REQ(WDT_RESET_REQ),
        .POWER_MODE(POWER_MODE), .CPU_RUN(CPU_RUN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
        .OSC_EN(OSC_EN), .RC_OSC_EN(RC_OSC_EN), .BROWNOUT_EN(BROWNOUT_EN), .CMP_EN(CMP_EN),
        .RTC_RUN(RTC_RUN), .WDT_RUN(WDT_RUN), .WAKE_RESET(WAKE_RESET), .WAKE_IRQ(WAKE_IRQ));

    wake_source_model u_src (.clk(CLK), .arst_n(ARST_N), .raise(raise), .drop(drop),
        .serviced(WAKE_IRQ), .irq_req(IRQ_REQ));

    always #12.5 CLK = ~CLK;

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (fails == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // The gap first lets stale synchronised requests drain, else the new sleep ends at once.
    task automatic enter(input logic [1:0] m);
        repeat (4) @(negedge CLK);
        MODE_WE = 1'b1;
        MODE_WDATA = m;
        @(negedge CLK);
        MODE_WE = 1'b0;
        repeat (3) @(negedge CLK);
    endtask

    task automatic fire(input int i);
        raise = 6'h01 << i;
        @(negedge CLK);
        raise = 6'h00;
    endtask

    // The synchroniser still shows the old request for two more edges, so wait it out.
    task automatic clear_src;
        drop = 1'b1;
        @(negedge CLK);
        drop = 1'b0;
        repeat (3) @(negedge CLK);
    endtask

    task automatic stays;
        repeat (12) @(negedge CLK);
        check({15'h0, CPU_RUN}, 16'h0000);
    endtask

    task automatic wait_run;
        n = 0;
        saw_irq = 1'b0;
        saw_rst = 1'b0;
        while (CPU_RUN !== 1'b1 && n < 3000) begin
            @(negedge CLK);
            n++;
            saw_irq |= WAKE_IRQ;
            saw_rst |= WAKE_RESET;
        end
        @(negedge CLK);
        saw_irq |= WAKE_IRQ;
        saw_rst |= WAKE_RESET;
    endtask

    initial begin
        {ARST_N, MODE_WE, MODE_WDATA, XTAL_SELECTED, RC_IS_SYSCLK, drop, raise} = '0;
        {RTC_POWER_OFF, CMP_POWER_OFF, RESET_REQ, WDT_RESET_REQ} = '0;
        {GLOBAL_IRQ_ENABLE, RTC_ENABLE, CMP_ENABLE, WATCHDOG_CLOCK_SELECT, RESET_ENABLE} = '1;
        IRQ_ENABLE = 6'h3f;
        repeat (8) @(negedge CLK);
        ARST_N = 1'b1;
        @(negedge CLK);
        check({POWER_MODE, CPU_RUN, OSC_EN, PERIPH_CLK_EN, WAKE_IRQ, WAKE_RESET}, 16'h1c);
        enter(2'h1);
        check({POWER_MODE, CPU_RUN, PERIPH_CLK_EN, OSC_EN}, 16'h0b);
        enter(2'h2);
        check({POWER_MODE, CPU_RUN, PERIPH_CLK_EN, OSC_EN}, 16'h0b);
        IRQ_ENABLE = 6'h3e;
        fire(0);
        stays();
        clear_src();
        IRQ_ENABLE = 6'h3f;
        GLOBAL_IRQ_ENABLE = 1'b0;
        fire(0);
        stays();
        clear_src();
        GLOBAL_IRQ_ENABLE = 1'b1;
        fire(2);
        wait_run();
        check({n <= 8, saw_irq, POWER_MODE}, 16'h0c);
        enter(2'h1);
        RESET_ENABLE = 1'b0;
        RESET_REQ = 1'b1;
        stays();
        RESET_ENABLE = 1'b1;
        wait_run();
        RESET_REQ = 1'b0;
        check({n <= 8, saw_rst}, 16'h03);
        for (int i = 0; i < 6; i++) begin
            enter(2'h2);
            check({POWER_MODE, CPU_RUN, OSC_EN, RC_OSC_EN, BROWNOUT_EN, CMP_EN, RTC_RUN,
                   WDT_RUN}, 16'h010f);
            fire(i);
            wait_run();
            check({n >= RC_N && n <= RC_N + 10, saw_irq}, 16'h03);
        end
        XTAL_SELECTED = 1'b1;
        enter(2'h2);
        fire(3);
        wait_run();
        check({n >= XTAL_N && n <= XTAL_N + 10, saw_irq}, 16'h03);
        {XTAL_SELECTED, CMP_ENABLE, WATCHDOG_CLOCK_SELECT} = 3'h0;
        {RC_IS_SYSCLK, CMP_POWER_OFF, RTC_POWER_OFF} = 3'h7;
        enter(2'h2);
        check({RC_OSC_EN, CMP_EN, RTC_RUN, WDT_RUN}, 16'h08);
        fire(4);
        stays();
        clear_src();
        WDT_RESET_REQ = 1'b1;
        stays();
        WDT_RESET_REQ = 1'b0;
        RESET_REQ = 1'b1;
        wait_run();
        RESET_REQ = 1'b0;
        check({n <= RC_N + 10, saw_rst}, 16'h03);
        {RC_IS_SYSCLK, CMP_POWER_OFF, RTC_POWER_OFF} = 3'h0;
        {CMP_ENABLE, WATCHDOG_CLOCK_SELECT} = 2'h3;
        enter(2'h3);
        check({POWER_MODE, BROWNOUT_EN, CMP_EN, OSC_EN, RC_OSC_EN}, 16'h30);
        fire(1);
        stays();
        clear_src();
        fire(5);
        stays();
        clear_src();
        for (int k = 0; k < 4; k++) begin
            fire(total_src[k]);
            wait_run();
            check({n <= RC_N + 10, saw_irq}, 16'h03);
            enter(2'h3);
        end
        WDT_RESET_REQ = 1'b1;
        wait_run();
        WDT_RESET_REQ = 1'b0;
        check({n <= RC_N + 10, saw_rst}, 16'h03);
        enter(2'h2);
        ARST_N = 1'b0;
        @(negedge CLK);
        check({POWER_MODE, CPU_RUN, OSC_EN, PERIPH_CLK_EN, WAKE_IRQ, WAKE_RESET}, 16'h1c);
        ARST_N = 1'b1;
        enter(2'h0);
        check({POWER_MODE, CPU_RUN, OSC_EN, WAKE_IRQ}, 16'h06);
        end_of_test();
    end
endmodule // power_reduction_mode_control_test

// ===== verif/wake_source_model.sv
// Behavioural model of the peripheral interrupt sources that wake the controller.
`timescale 1ns/1ps
module wake_source_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Requests from the bench and service from the core
    input  wire logic [5:0] raise,
    input  wire logic       drop,
    input  wire logic       serviced,
    // Request levels towards the controller
    output logic      [5:0] irq_req
);
    // A source holds its flag until the core services it or the bench drops it, so a slow wake still sees it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_req <= 6'h00;
        end else if (drop || serviced) begin
            irq_req <= 6'h00;
        end else begin
            irq_req <= irq_req | raise;
        end
    end
endmodule // wake_source_model
